// ---- design/pcd_clock_control.sv ----
/*
  Clock control block: bandgap and PLL enables, PLL lock report, rate
  multipliers for the ADC, metering and CPU clocks, crystal failure and
  comparator report, all behind an APB slave with a level interrupt.
  Assumes analog status inputs are asynchronous and that the analog
  clock generators consume the tick and multiplier outputs.
*/
//
// Behaviour
// (R1) lock flag in bit0, upper bits zero
// (R2) pll enable bit, 0 off, reset off
// (R3) bandgap enable bit, 0 off, reset off
// (R4) software enables bandgap before pll
// (R5) adc clock 204.8 kHz times 1,2,4
// (R6) metering clock 819.2 kHz times 1,2,4
// (R7) cpu clock 819.2 kHz times 1,2,4,8
// (R8) first doubler doubles cpu clock
// (R9) second doubler works only with first
// (R10) crystal stop flag, fall back to rc
// (R11) comparator output reported in bit5
// (R12) software moves system clock to pll
// (R13) reserved code 11 gives times one
// (R14) rate changes only at period boundaries
module pcd_clock_control (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pllLockRaw,
  input  wire logic        xtalStoppedRaw,
  input  wire logic        auxComparatorRaw,
  output logic             pllPowerEnable,
  output logic             bandgapPowerEnable,
  output logic             rcClockFallback,
  output logic             adcSampleTick,
  output logic      [2:0]  adcSampleMult,
  output logic             meterEngineTick,
  output logic      [2:0]  meterEngineMult,
  output logic      [5:0]  cpuCoreMult,
  output logic             irq
);

  pcd_pkg::pcd_clkctl_t ctl;
  pcd_pkg::pcd_dbl_t    dbl;
  logic [pcd_pkg::NEV-1:0] irqStat;
  logic [pcd_pkg::NEV-1:0] irqMask;
  logic [pcd_pkg::NEV-1:0] events;
  logic [2:0]  rawIn;
  logic [2:0]  syncF;
  logic        lockedFlag;
  logic        xtalPrev;
  logic        compPrev;
  logic [31:0] next_prdata;
  logic        mapped;
  logic        wrDone;
  logic [13:0] idx;
  logic [2:0]  reqMult [2];
  logic [2:0]  actMult [2];
  logic        tickQ   [2];
  logic        carry   [2];
  logic [2:0]  cpuShift;

  function automatic logic [2:0] pcd_mult3(input logic [1:0] sel);
    case (sel)
      2'b01:   return 3'h2;
      2'b10:   return 3'h4;
      default: return 3'h1; // [R13]
    endcase
  endfunction

  // input synchronisers, change accepted when stages two and three agree
  assign rawIn = {auxComparatorRaw, xtalStoppedRaw, pllLockRaw};
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gSync
      logic [2:0] s;
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          s <= 3'h0;
          syncF[g] <= 1'b0;
        end else begin
          s <= {s[1:0], rawIn[g]};
          if (s[1] == s[2]) begin
            syncF[g] <= s[2];
          end
        end
      end
    end
  endgenerate

  // apb decode
  assign idx    = paddr[15:2];
  assign wrDone = psel & penable & pready & pwrite;
  always_comb begin
    next_prdata = 32'h0;
    mapped = (paddr[1:0] == 2'h0);
    case (idx)
      pcd_pkg::IDX_LOCK:   next_prdata[0] = lockedFlag; // [R1]
      pcd_pkg::IDX_CLKCTL: next_prdata[7:0] = ctl;
      pcd_pkg::IDX_DBL: begin
        next_prdata[pcd_pkg::DBL2_BIT] = dbl.cpuClockSecondDoubler;
        next_prdata[pcd_pkg::DBL1_BIT] = dbl.cpuClockFirstDoubler;
      end
      pcd_pkg::IDX_ANA: begin
        next_prdata[pcd_pkg::ANA_XTAL_BIT] = rcClockFallback; // [R10]
        next_prdata[pcd_pkg::ANA_COMP_BIT] = syncF[2]; // [R11]
        next_prdata[4:2] = pcd_pkg::ANA_FIXED;
      end
      pcd_pkg::IDX_IRQ_STAT: next_prdata[pcd_pkg::NEV-1:0] = irqStat;
      pcd_pkg::IDX_IRQ_MASK: next_prdata[pcd_pkg::NEV-1:0] = irqMask;
      default: mapped = 1'b0;
    endcase
  end

  // one wait-free access phase: answer registered during setup
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= pwrite ? 32'h0 : next_prdata;
      pready  <= 1'b1;
      pslverr <= !mapped;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // control registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctl <= pcd_pkg::CLKCTL_RST; // [R2] [R3]
      dbl <= pcd_pkg::DBL_RST;
      irqMask <= pcd_pkg::MASK_RST;
    end else if (wrDone && !pslverr) begin
      case (idx)
        pcd_pkg::IDX_CLKCTL: ctl <= pwdata[7:0]; // [R2] [R3]
        pcd_pkg::IDX_DBL: begin
          dbl.cpuClockSecondDoubler <= pwdata[pcd_pkg::DBL2_BIT];
          dbl.cpuClockFirstDoubler  <= pwdata[pcd_pkg::DBL1_BIT];
        end
        pcd_pkg::IDX_IRQ_MASK: irqMask <= pwdata[pcd_pkg::NEV-1:0];
        default: ;
      endcase
    end
  end

  // analog enables; bandgap-first order is left to software
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pllPowerEnable     <= 1'b0;
      bandgapPowerEnable <= 1'b0;
    end else begin
      pllPowerEnable     <= ctl.pllPowerEnable; // [R2] [R4]
      bandgapPowerEnable <= ctl.bandgapPowerEnable; // [R3]
    end
  end

  // status flags
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lockedFlag      <= 1'b0;
      rcClockFallback <= 1'b0;
      xtalPrev        <= 1'b0;
      compPrev        <= 1'b0;
    end else begin
      lockedFlag      <= syncF[0] & pllPowerEnable; // [R1]
      rcClockFallback <= syncF[1]; // [R10]
      xtalPrev        <= rcClockFallback;
      compPrev        <= syncF[2];
    end
  end

  // sticky events, a set in the clearing cycle wins
  assign events[pcd_pkg::EV_LOCK] = syncF[0] & pllPowerEnable & !lockedFlag;
  assign events[pcd_pkg::EV_XTAL] = rcClockFallback & !xtalPrev;
  assign events[pcd_pkg::EV_COMP] = syncF[2] ^ compPrev;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irqStat <= '0;
      irq     <= 1'b0;
    end else begin
      if (wrDone && !pslverr && idx == pcd_pkg::IDX_IRQ_STAT) begin
        irqStat <= (irqStat & ~pwdata[pcd_pkg::NEV-1:0]) | events;
      end else begin
        irqStat <= irqStat | events;
      end
      irq <= |(irqStat & irqMask);
    end
  end

  // rate generators; new multiple applied only at a period boundary
  assign reqMult[0] = pcd_mult3(ctl.adcClockMultiplier); // [R5]
  assign reqMult[1] = pcd_mult3(ctl.meterClockMultiplier); // [R6]
  generate
    for (g = 0; g < 2; g++) begin : gRate
      localparam logic [pcd_pkg::ACC_W-1:0] BASE =
        (g == 0) ? pcd_pkg::ADC_INC : pcd_pkg::METER_INC;
      logic [pcd_pkg::ACC_W-1:0] acc;
      logic [pcd_pkg::ACC_W:0]   sum;
      assign sum = {1'b0, acc} +
        (pcd_pkg::ACC_W + 1)'(BASE * actMult[g]); // [R5] [R6]
      assign carry[g] = sum[pcd_pkg::ACC_W];
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          acc        <= '0;
          tickQ[g]   <= 1'b0;
          actMult[g] <= 3'h1;
        end else begin
          acc      <= sum[pcd_pkg::ACC_W-1:0];
          tickQ[g] <= sum[pcd_pkg::ACC_W];
          if (sum[pcd_pkg::ACC_W]) begin
            actMult[g] <= reqMult[g]; // [R14]
          end
        end
      end
    end
  endgenerate
  assign adcSampleTick   = tickQ[0];
  assign adcSampleMult   = actMult[0];
  assign meterEngineTick = tickQ[1];
  assign meterEngineMult = actMult[1];

  // cpu multiple: selector, first doubler, second only with first
  assign cpuShift = {1'b0, ctl.cpuClockMultiplier} // [R7]
    + {2'b0, dbl.cpuClockFirstDoubler} // [R8]
    + {2'b0, dbl.cpuClockFirstDoubler & dbl.cpuClockSecondDoubler}; // [R9]
  // taken on the meter carry, so it moves together with the meter tick
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cpuCoreMult <= 6'h01;
    end else if (carry[1]) begin
      cpuCoreMult <= 6'h01 << cpuShift; // [R14]
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // register bus and read-back
  a_bus_answer: assert property (psel && !penable |=> pready)
    else $error("no answer in first access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_lock_read: assert property (psel && !penable && !pwrite && // [R1]
      idx == pcd_pkg::IDX_LOCK |=> prdata == {31'h0, $past(lockedFlag)})
    else $error("lock register read wrong");
  a_ana_read: assert property (psel && !penable && !pwrite && // [R10] [R11]
      idx == pcd_pkg::IDX_ANA |=> prdata == {24'h0,
      $past(rcClockFallback), 1'b0, $past(syncF[2]),
      pcd_pkg::ANA_FIXED, 2'h0})
    else $error("analog status read wrong");

  // enables
  a_ctl_hold: assert property ($changed(ctl) |-> // [R2] [R3]
      $past(wrDone && !pslverr && idx == pcd_pkg::IDX_CLKCTL))
    else $error("clock control changed without a write");
  a_pll_write: assert property (wrDone && !pslverr && // [R2]
      idx == pcd_pkg::IDX_CLKCTL |=> ##1 pllPowerEnable ==
      $past(pwdata[7], 2))
    else $error("pll enable does not follow write");
  a_bg_write: assert property (wrDone && !pslverr && // [R3]
      idx == pcd_pkg::IDX_CLKCTL |=> ##1 bandgapPowerEnable ==
      $past(pwdata[6], 2))
    else $error("bandgap enable does not follow write");

  // status flags and interrupt
  a_lock_off: assert property (!pllPowerEnable |=> !lockedFlag) // [R1]
    else $error("lock flag set while pll is off");
  a_lock_gain: assert property ($rose(lockedFlag) |-> // [R1]
      irqStat[pcd_pkg::EV_LOCK])
    else $error("lock gain not reported");
  a_rc_follow: assert property (rcClockFallback == $past(syncF[1])) // [R10]
    else $error("fallback flag does not follow crystal state");
  a_xtal_follow: assert property ($rose(syncF[1]) |=> // [R10]
      rcClockFallback ##1 irqStat[pcd_pkg::EV_XTAL])
    else $error("crystal stop not reported");
  a_comp_follow: assert property ($changed(syncF[2]) |=> // [R11]
      irqStat[pcd_pkg::EV_COMP])
    else $error("comparator change not reported");
  a_stat_sticky: assert property ((($past(irqStat) & ~irqStat) != '0) |->
      $past(wrDone && !pslverr && idx == pcd_pkg::IDX_IRQ_STAT))
    else $error("status bit cleared without a write");
  a_irq_level: assert property (irq == $past(|(irqStat & irqMask)))
    else $error("interrupt does not follow status and mask");

  // rates
  a_adc_code: assert property (adcSampleTick |-> adcSampleMult == // [R5]
      pcd_mult3($past(ctl.adcClockMultiplier)))
    else $error("adc multiple wrong");
  a_meter_code: assert property (meterEngineTick |-> // [R6]
      meterEngineMult == pcd_mult3($past(ctl.meterClockMultiplier)))
    else $error("meter multiple wrong");
  a_adc_period: assert property (adcSampleTick |=> // [R5]
      !adcSampleTick [*8])
    else $error("adc tick too close");
  a_meter_period: assert property (meterEngineTick |=> // [R6]
      !meterEngineTick [*5])
    else $error("meter tick too close");
  a_adc_reserved: assert property (adcSampleTick && // [R13]
      $past(ctl.adcClockMultiplier) == 2'b11 |-> adcSampleMult == 3'h1)
    else $error("reserved adc code not times one");
  a_meter_reserved: assert property (meterEngineTick && // [R13]
      $past(ctl.meterClockMultiplier) == 2'b11 |->
      meterEngineMult == 3'h1)
    else $error("reserved code not times one");
  a_cpu_plain: assert property (meterEngineTick && // [R7]
      $past(!dbl.cpuClockFirstDoubler) |-> cpuCoreMult ==
      6'h01 << $past(ctl.cpuClockMultiplier))
    else $error("cpu multiple wrong without doubling");
  a_cpu_first: assert property (meterEngineTick && // [R8]
      $past(dbl.cpuClockFirstDoubler && !dbl.cpuClockSecondDoubler) |->
      cpuCoreMult == 6'h02 << $past(ctl.cpuClockMultiplier))
    else $error("first doubler wrong");
  a_cpu_second: assert property (meterEngineTick && // [R9]
      $past(dbl.cpuClockFirstDoubler && dbl.cpuClockSecondDoubler) |->
      cpuCoreMult == 6'h04 << $past(ctl.cpuClockMultiplier))
    else $error("second doubler wrong");
  a_rate_change: assert property ($changed(adcSampleMult) |-> // [R14]
      adcSampleTick)
    else $error("adc multiple changed mid period");
  a_meter_change: assert property ($changed(meterEngineMult) |-> // [R14]
      meterEngineTick)
    else $error("meter multiple changed mid period");
  a_cpu_change: assert property ($changed(cpuCoreMult) |-> // [R14]
      meterEngineTick)
    else $error("cpu multiple changed mid period");

  c_lock_seen: cover property ($rose(lockedFlag));
  c_cpu_max: cover property (cpuCoreMult == 6'h20);
  c_irq_rise: cover property ($rose(irq));
  c_adc_switch: cover property ($changed(adcSampleMult));
  c_reserved: cover property (meterEngineTick &&
      $past(ctl.meterClockMultiplier) == 2'b11);
endmodule

// ---- include/pcd_pkg.sv ----
/*
  Shared constants and types for the clock control block: register
  indices, field positions, reset values, rate constants and carriers.
  Assumes a 20 MHz system clock and an APB master with 32-bit data.
*/
package pcd_pkg;
  // rates
  localparam longint CLK_HZ        = 20000000;
  localparam longint ADC_BASE_HZ   = 204800;
  localparam longint METER_BASE_HZ = 819200;
  localparam int     ACC_W         = 24;
  localparam logic [ACC_W-1:0] ADC_INC =
    ACC_W'((ADC_BASE_HZ << ACC_W) / CLK_HZ);
  localparam logic [ACC_W-1:0] METER_INC =
    ACC_W'((METER_BASE_HZ << ACC_W) / CLK_HZ);

  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_LOCK     = 14'h00a3;
  localparam logic [13:0] IDX_CLKCTL   = 14'h2867;
  localparam logic [13:0] IDX_DBL      = 14'h2868;
  localparam logic [13:0] IDX_ANA      = 14'h286b;
  localparam logic [13:0] IDX_IRQ_STAT = 14'h2870;
  localparam logic [13:0] IDX_IRQ_MASK = 14'h2871;

  // field positions
  localparam int DBL1_BIT     = 6;
  localparam int DBL2_BIT     = 7;
  localparam int ANA_XTAL_BIT = 7;
  localparam int ANA_COMP_BIT = 5;
  localparam logic [2:0] ANA_FIXED = 3'h5;

  // reset values
  localparam logic [7:0] CLKCTL_RST = 8'h00;
  localparam logic [1:0] DBL_RST    = 2'h0;
  localparam logic [2:0] MASK_RST   = 3'h0;

  // interrupt events
  localparam int EV_LOCK = 0;
  localparam int EV_XTAL = 1;
  localparam int EV_COMP = 2;
  localparam int NEV     = 3;

  typedef struct packed {
    logic       pllPowerEnable;
    logic       bandgapPowerEnable;
    logic [1:0] adcClockMultiplier;
    logic [1:0] meterClockMultiplier;
    logic [1:0] cpuClockMultiplier;
  } pcd_clkctl_t;

  typedef struct packed {
    logic cpuClockSecondDoubler;
    logic cpuClockFirstDoubler;
  } pcd_dbl_t;
endpackage

// ---- tb/tb.sv ----
/*
  Self-checking bench for the clock control block: register access,
  enables, lock report, rate multipliers, status report and interrupt.
  Assumes the design's own assertions run beside it and a 20 MHz clock.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pllLockRaw;
  logic        xtalStoppedRaw;
  logic        auxComparatorRaw;
  logic        pllPowerEnable;
  logic        bandgapPowerEnable;
  logic        rcClockFallback;
  logic        adcSampleTick;
  logic [2:0]  adcSampleMult;
  logic        meterEngineTick;
  logic [2:0]  meterEngineMult;
  logic [5:0]  cpuCoreMult;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          errors;
  int          num_checks;

  pcd_clock_control i_dut (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pllLockRaw(pllLockRaw), .xtalStoppedRaw(xtalStoppedRaw),
    .auxComparatorRaw(auxComparatorRaw), .pllPowerEnable(pllPowerEnable),
    .bandgapPowerEnable(bandgapPowerEnable),
    .rcClockFallback(rcClockFallback), .adcSampleTick(adcSampleTick),
    .adcSampleMult(adcSampleMult), .meterEngineTick(meterEngineTick),
    .meterEngineMult(meterEngineMult), .cpuCoreMult(cpuCoreMult),
    .irq(irq));

  always #25 clk = ~clk;

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [13:0] idx,
                     input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ends on a rising edge; outputs read here are last cycle's values
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic waitTick(input logic meter);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((meter ? meterEngineTick : adcSampleTick) !== 1'b1
               && n < 400);
    if (n >= 400) chk("tick", 32'h0, 32'h1);
  endtask

  task automatic testReset;
    apb(0, pcd_pkg::IDX_CLKCTL, 0);
    chk("clkctl", rd, 32'(pcd_pkg::CLKCTL_RST));
    apb(0, pcd_pkg::IDX_DBL, 0);
    chk("dbl", rd, 32'h0);
    apb(0, pcd_pkg::IDX_LOCK, 0);
    chk("lock", rd, 32'h0);
    apb(0, pcd_pkg::IDX_ANA, 0);
    chk("ana", rd, 32'h14);
    chk("en", {30'h0, pllPowerEnable, bandgapPowerEnable}, 32'h0);
    apb(0, 14'h0001, 0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    $display("test reset done");
  endtask

  task automatic testEnable;
    apb(1, pcd_pkg::IDX_CLKCTL, 32'h40);
    idle(2);
    chk("bg", {30'h0, pllPowerEnable, bandgapPowerEnable}, 32'h1);
    pllLockRaw <= 1'b1;
    idle(6);
    apb(0, pcd_pkg::IDX_LOCK, 0);
    chk("lock off", rd, 32'h0);
    apb(1, pcd_pkg::IDX_CLKCTL, 32'hc0);
    idle(2);
    chk("pll", {30'h0, pllPowerEnable, bandgapPowerEnable}, 32'h3);
    idle(6);
    apb(1, pcd_pkg::IDX_LOCK, 32'h0);
    chk("ro err", {31'h0, err}, 32'h0);
    apb(0, pcd_pkg::IDX_LOCK, 0);
    chk("lock on", rd, 32'h1);
    $display("test enable done");
  endtask

  task automatic testRates;
    int ca;
    int cm;
    longint m;
    for (int c = 0; c < 4; c++) begin
      m = (c == 1) ? 2 : (c == 2) ? 4 : 1;
      apb(1, pcd_pkg::IDX_CLKCTL, 32'hc0 | 32'(c << 4) | 32'(c << 2));
      waitTick(0);
      waitTick(0);
      chk("adc mult", 32'(adcSampleMult), 32'(m));
      chk("mtr mult", 32'(meterEngineMult), 32'(m));
      ca = 0;
      cm = 0;
      repeat (2000) begin
        @(posedge clk);
        ca += int'(adcSampleTick === 1'b1);
        cm += int'(meterEngineTick === 1'b1);
      end
      m = 2000 * m;
      chk("adc rate", 32'(ca - (m * pcd_pkg::ADC_BASE_HZ) / pcd_pkg::CLK_HZ)
          >> 1, 32'h0);
      chk("mtr rate", 32'(cm - (m * pcd_pkg::METER_BASE_HZ) / pcd_pkg::CLK_HZ)
          >> 1, 32'h0);
    end
    $display("test rates done");
  endtask

  task automatic testCpu;
    for (int s = 0; s < 4; s++) begin
      for (int d = 0; d < 4; d++) begin
        apb(1, pcd_pkg::IDX_CLKCTL, 32'hc0 | 32'(s));
        apb(1, pcd_pkg::IDX_DBL, 32'(d << 6));
        apb(0, pcd_pkg::IDX_DBL, 0);
        chk("dbl rd", rd, 32'(d << 6));
        waitTick(1);
        waitTick(1);
        chk("cpu mult", 32'(cpuCoreMult),
            32'(1 << (s + d[0] + (d[0] & d[1]))));
      end
    end
    $display("test cpu done");
  endtask

  task automatic testStatus;
    apb(0, pcd_pkg::IDX_IRQ_STAT, 0);
    chk("stat lock", rd, 32'h1);
    apb(1, pcd_pkg::IDX_IRQ_STAT, rd);
    xtalStoppedRaw <= 1'b1;
    auxComparatorRaw <= 1'b1;
    idle(6);
    chk("fallback", 32'(rcClockFallback), 32'h1);
    apb(0, pcd_pkg::IDX_ANA, 0);
    chk("ana set", rd, 32'hb4);
    chk("irq masked", 32'(irq), 32'h0);
    apb(1, pcd_pkg::IDX_IRQ_MASK, 32'h2);
    idle(2);
    chk("irq on", 32'(irq), 32'h1);
    apb(1, pcd_pkg::IDX_IRQ_STAT, 32'h2);
    idle(2);
    chk("irq off", 32'(irq), 32'h0);
    apb(0, pcd_pkg::IDX_IRQ_STAT, 0);
    chk("stat", rd, 32'h4);
    xtalStoppedRaw <= 1'b0;
    auxComparatorRaw <= 1'b0;
    idle(6);
    apb(0, pcd_pkg::IDX_ANA, 0);
    chk("ana clr", rd, 32'h14);
    $display("test status done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(50 * 40000);
    errors++;
    wrap_up();
  end

  initial begin
    clk = 0;
    rst_b = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    pllLockRaw = 0;
    xtalStoppedRaw = 0;
    auxComparatorRaw = 0;
    errors = 0;
    num_checks = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    testReset();
    testEnable();
    testRates();
    testCpu();
    testStatus();
    wrap_up();
  end
endmodule
